/* File: src/lsc_pkg.sv */
/*
 Package for the supply-controller serial slave: address, register layout,
 output level codes and the carrier structs shared by the design files.
 Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package lsc_pkg;
	// Address and direction
	localparam logic [5:0] LSC_ADDR_HI = 6'h05;
	localparam int LSC_DIR_READ = 1;
	// Register reset value
	localparam logic [7:0] LSC_REG_RST = 8'h00;
	// Write field positions
	localparam int LSC_W_CUR_STYLE = 7;
	localparam int LSC_W_TONE_PATH = 6;
	localparam int LSC_W_TONE_CONT = 5;
	localparam int LSC_W_LLC = 4;
	localparam int LSC_W_VOLTAGE_SELECT = 3;
	localparam int LSC_W_EN = 2;
	localparam int LSC_W_ITHR = 1;
	localparam int LSC_W_AUX = 0;
	// Output level codes
	localparam logic [2:0] LSC_LVL_OFF = 3'h0;
	localparam logic [2:0] LSC_LVL_13V4 = 3'h1;
	localparam logic [2:0] LSC_LVL_18V5 = 3'h2;
	localparam logic [2:0] LSC_LVL_14V4 = 3'h3;
	localparam logic [2:0] LSC_LVL_19V5 = 3'h4;
	localparam logic [2:0] LSC_LVL_22V = 3'h5;

	typedef struct packed {
		logic min_current_fault;
		logic voltage_fault;
		logic tone_fault;
		logic over_temp_flag;
		logic overload_flag;
	} lsc_diag_t;

	typedef struct packed {
		logic [2:0] level;
		logic power_on;
		logic main_output_on;
		logic tone_output_on;
		logic tone_active;
		logic static_limit;
		logic high_min_thresh;
	} lsc_ctrl_t;

	// Decode of a sampled two-wire bus pair into edge/condition events
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} lsc_bus_ev_t;
endpackage

/* File: src/lsc_bus_sync.sv */
/*
 Synchroniser and event finder for the two bus pins and the address pin.
 Assumes pins are asynchronous to SYS_CLK_IN and the bus clock is far slower.
*/
`timescale 1ns/1ns
`default_nettype none
module lsc_bus_sync import lsc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic addr_sel_in,
	output lsc_bus_ev_t ev_out,
	output logic addr_sel_out
);
	logic [1:0] scl_s_r, scl_s_nxt;
	logic [1:0] sda_s_r, sda_s_nxt;
	logic [1:0] adr_s_r, adr_s_nxt;
	logic scl_d_r, scl_d_nxt;
	logic sda_d_r, sda_d_nxt;

	always_comb begin
		scl_s_nxt = {scl_s_r[0], scl_in};
		sda_s_nxt = {sda_s_r[0], sda_in};
		adr_s_nxt = {adr_s_r[0], addr_sel_in};
		scl_d_nxt = scl_s_r[1];
		sda_d_nxt = sda_s_r[1];
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			adr_s_r <= 2'h0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s_r <= scl_s_nxt;
			sda_s_r <= sda_s_nxt;
			adr_s_r <= adr_s_nxt;
			scl_d_r <= scl_d_nxt;
			sda_d_r <= sda_d_nxt;
		end
	end

	// Only second stages and their delayed copies feed the decode
	always_comb begin
		ev_out.scl_rise = scl_s_r[1] & ~scl_d_r;
		ev_out.scl_fall = ~scl_s_r[1] & scl_d_r;
		ev_out.start = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
		ev_out.stop = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];
		ev_out.sda = sda_s_r[1];
	end
	assign addr_sel_out = adr_s_r[1];
endmodule
`default_nettype wire

/* File: src/lsc_ctrl_decode.sv */
/*
 Decodes the control byte into power, level, tone and limit controls.
 Assumes a registered control byte and a registered tone gate level.
*/
`timescale 1ns/1ns
`default_nettype none
module lsc_ctrl_decode import lsc_pkg::*; (
	input wire logic [7:0] ctrl_in,
	input wire logic tone_gate_in,
	output lsc_ctrl_t ctrl_out
);
	logic en;

	always_comb begin
		en = ctrl_in[LSC_W_EN];
		// Enable low masks every other control bit
		ctrl_out.power_on = en;
		ctrl_out.main_output_on = en;
		ctrl_out.tone_output_on = en & ctrl_in[LSC_W_TONE_PATH];
		// Continuous tone or gated by the tone gate pin
		ctrl_out.tone_active = en & ctrl_in[LSC_W_TONE_PATH] &
			(ctrl_in[LSC_W_TONE_CONT] | tone_gate_in);
		ctrl_out.static_limit = en & ctrl_in[LSC_W_CUR_STYLE];
		ctrl_out.high_min_thresh = en & ctrl_in[LSC_W_ITHR];
		// Level choice; aux forces the top level
		if (!en) begin
			ctrl_out.level = LSC_LVL_OFF;
		end else if (ctrl_in[LSC_W_AUX]) begin
			ctrl_out.level = LSC_LVL_22V;
		end else begin
			unique case ({ctrl_in[LSC_W_LLC], ctrl_in[LSC_W_VOLTAGE_SELECT]})
				2'b00: ctrl_out.level = LSC_LVL_13V4;
				2'b01: ctrl_out.level = LSC_LVL_18V5;
				2'b10: ctrl_out.level = LSC_LVL_14V4;
				2'b11: ctrl_out.level = LSC_LVL_19V5;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: src/lsc_top.sv */
/*
 Two-wire serial slave holding the single system register of a satellite
 supply controller, with control decode and diagnostic readback.
 Assumes open-drain bus with external pull-ups; analog detectors deliver
 fault levels asynchronously, so they are synchronised here.
*/
// Contract
// - Device pulls data low on ninth clock
// - No acknowledge during undervoltage lockout
// - Start, address, data with acknowledges, stop
// - Address 000101X, low bit selects direction
// - Address bit X follows select pin
// - Write loads all eight control bits
// - Read returns faults, three settings, flags
// - Register clears to zero at power-on
// - Enable, aux, compensation, select pick level
// - Tone continuous or gated by input
// - Tone path switches tone output only; here it also gates TONE_ACTIVE_OUT
// - Style bit picks pulsed or static limit
// - Threshold bit picks low or high
// - Read shifts register out MSB first
// - Master acknowledge continues, nack ends read
// - Settings read back exactly as written
// - Diagnostic flags read one while fault
// - Temperature and overload flags mirror detectors
// - Monitor faults set when out of limits
// - Lockout ignores bus, holds register zero
`timescale 1ns/1ns
`default_nettype none
module lsc_top import lsc_pkg::*; (
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	// Serial bus pins
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N_OUT,
	input wire logic ADDR_SEL_IN,
	// Supply and detectors
	input wire logic UNDERVOLTAGE_LOCKOUT_IN,
	input wire logic TONE_GATE_IN,
	input wire logic MIN_CURRENT_FAULT_IN,
	input wire logic VOLTAGE_FAULT_IN,
	input wire logic TONE_FAULT_IN,
	input wire logic OVER_TEMP_IN,
	input wire logic OVERLOAD_IN,
	// Control outputs
	output logic [2:0] LEVEL_OUT,
	output logic POWER_ON_OUT,
	output logic MAIN_OUTPUT_ON_OUT,
	output logic TONE_OUTPUT_ON_OUT,
	output logic TONE_ACTIVE_OUT,
	output logic STATIC_LIMIT_OUT,
	output logic HIGH_MIN_THRESH_OUT
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b010,
		ST_ACK = 3'b110,
		ST_MACK = 3'b111,
		ST_WAIT = 3'b101
	} lsc_state_t;

	lsc_bus_ev_t ev;
	logic addr_sel;
	lsc_ctrl_t ctrl;
	lsc_diag_t diag;
	logic [6:0] async_s1_r, async_s2_r;
	logic undervoltage_lockout, tone_gate;

	lsc_bus_sync u_sync (
		.clk_in(SYS_CLK_IN),
		.rst_in(SYS_RST_IN),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.addr_sel_in(ADDR_SEL_IN),
		.ev_out(ev),
		.addr_sel_out(addr_sel)
	);

	// Detector and gate levels come from analog, so two stages each
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			async_s1_r <= 7'h00;
			async_s2_r <= 7'h00;
		end else begin
			async_s1_r <= {UNDERVOLTAGE_LOCKOUT_IN, TONE_GATE_IN, MIN_CURRENT_FAULT_IN,
				VOLTAGE_FAULT_IN, TONE_FAULT_IN, OVER_TEMP_IN, OVERLOAD_IN};
			async_s2_r <= async_s1_r;
		end
	end
	assign undervoltage_lockout = async_s2_r[6];
	assign tone_gate = async_s2_r[5];
	assign diag = async_s2_r[4:0];

	lsc_state_t state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic rd_r, rd_nxt;
	logic sda_low_r, sda_low_nxt;
	logic [7:0] sysreg_r, sysreg_nxt;
	logic [7:0] rd_byte;

	function automatic logic addr_match(input logic [7:0] b, input logic x);
		return b[7:1] == {LSC_ADDR_HI, x};
	endfunction

	// Read image: faults, echoed settings, detector flags
	assign rd_byte = {diag.min_current_fault, diag.voltage_fault, diag.tone_fault,
		sysreg_r[LSC_W_LLC], sysreg_r[LSC_W_VOLTAGE_SELECT], sysreg_r[LSC_W_EN],
		diag.over_temp_flag, diag.overload_flag};

	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		bit_nxt = bit_r;
		rd_nxt = rd_r;
		sda_low_nxt = sda_low_r;
		sysreg_nxt = sysreg_r;
		// Lockout outranks START, so a sagging supply cannot be addressed
		if (undervoltage_lockout) begin
			// Lockout: bus ignored, register held at zero
			state_nxt = ST_IDLE;
			sda_low_nxt = 1'b0;
			sysreg_nxt = LSC_REG_RST;
		end else if (ev.start) begin
			state_nxt = ST_ADDR;
			bit_nxt = 3'h0;
			sda_low_nxt = 1'b0;
		end else if (ev.stop) begin
			state_nxt = ST_IDLE;
			sda_low_nxt = 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE, ST_WAIT: begin
				end
				ST_ADDR, ST_WDATA: begin
					if (ev.scl_rise) begin
						shift_nxt = {shift_r[6:0], ev.sda};
						bit_nxt = bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							state_nxt = ST_ACK;
						end
					end
				end
				ST_ACK: begin
					// Pulled on the fall after the eighth bit, so the line is
					// already low when the ninth clock rises
					if (ev.scl_fall && !sda_low_r) begin
						sda_low_nxt = 1'b1;
					end else if (ev.scl_fall && sda_low_r) begin
						// Ninth clock done, release or start the read byte
						sda_low_nxt = 1'b0;
						bit_nxt = 3'h0;
						if (rd_r) begin
							shift_nxt = rd_byte;
							sda_low_nxt = ~rd_byte[7];
							state_nxt = ST_RDATA;
						end else begin
							state_nxt = ST_WDATA;
						end
					end
				end
				ST_RDATA: begin
					// Bit 7 stands from entry; each fall moves one bit on
					if (ev.scl_fall) begin
						bit_nxt = bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							sda_low_nxt = 1'b0;
							state_nxt = ST_MACK;
						end else begin
							shift_nxt = {shift_r[6:0], 1'b0};
							sda_low_nxt = ~shift_r[6];
						end
					end
				end
				ST_MACK: begin
					// Master ack asks for another byte
					if (ev.scl_rise && ev.sda) begin
						state_nxt = ST_WAIT;
					end else if (ev.scl_fall) begin
						// Ack clock over: next byte starts with its MSB
						shift_nxt = rd_byte;
						sda_low_nxt = ~rd_byte[7];
						bit_nxt = 3'h0;
						state_nxt = ST_RDATA;
					end
				end
				default: state_nxt = ST_IDLE;
			endcase
		end
		// Byte acceptance at the eighth rising edge
		if (!undervoltage_lockout && !ev.start && !ev.stop && ev.scl_rise && bit_r == 3'h7 &&
				(state_r == ST_ADDR || state_r == ST_WDATA)) begin
			if (state_r == ST_ADDR) begin
				if (addr_match({shift_r[6:0], ev.sda}, addr_sel)) begin
					rd_nxt = (ev.sda == 1'(LSC_DIR_READ));
				end else begin
					state_nxt = ST_WAIT;
				end
			end else begin
				sysreg_nxt = {shift_r[6:0], ev.sda};
				rd_nxt = 1'b0;
			end
		end
		if (!undervoltage_lockout && state_r == ST_WAIT) begin
			sda_low_nxt = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			state_r <= ST_IDLE;
			shift_r <= 8'h00;
			bit_r <= 3'h0;
			rd_r <= 1'b0;
			sda_low_r <= 1'b0;
			sysreg_r <= LSC_REG_RST;
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			bit_r <= bit_nxt;
			rd_r <= rd_nxt;
			sda_low_r <= sda_low_nxt;
			sysreg_r <= sysreg_nxt;
		end
	end

	// Open drain: only ever pulls low
	assign SDA_OUT = 1'b0;
	assign SDA_OE_N_OUT = ~sda_low_r;

	// Control decode of the register byte
	lsc_ctrl_decode u_dec (
		.ctrl_in(sysreg_r),
		.tone_gate_in(tone_gate),
		.ctrl_out(ctrl)
	);

	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			LEVEL_OUT <= LSC_LVL_OFF;
			POWER_ON_OUT <= 1'b0;
			MAIN_OUTPUT_ON_OUT <= 1'b0;
			TONE_OUTPUT_ON_OUT <= 1'b0;
			TONE_ACTIVE_OUT <= 1'b0;
			STATIC_LIMIT_OUT <= 1'b0;
			HIGH_MIN_THRESH_OUT <= 1'b0;
		end else begin
			// Over-temperature also shuts power blocks
			LEVEL_OUT <= diag.over_temp_flag ? LSC_LVL_OFF : ctrl.level;
			POWER_ON_OUT <= ctrl.power_on & ~diag.over_temp_flag;
			MAIN_OUTPUT_ON_OUT <= ctrl.main_output_on & ~diag.over_temp_flag;
			TONE_OUTPUT_ON_OUT <= ctrl.tone_output_on & ~diag.over_temp_flag;
			TONE_ACTIVE_OUT <= ctrl.tone_active & ~diag.over_temp_flag;
			STATIC_LIMIT_OUT <= ctrl.static_limit;
			HIGH_MIN_THRESH_OUT <= ctrl.high_min_thresh;
		end
	end

	a_uvl_no_ack: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
		$past(undervoltage_lockout) |-> SDA_OE_N_OUT) else $error("acknowledge during lockout");
	a_uvl_reg_zero: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
		undervoltage_lockout |=> sysreg_r == 8'h00) else $error("register not cleared in lockout");
	a_ack_low_held: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
		(state_r == ST_ACK && !SDA_OE_N_OUT && !ev.scl_fall && !undervoltage_lockout && !ev.start
		&& !ev.stop) |=> !SDA_OE_N_OUT) else $error("ack released early");
	a_wait_silent: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
		(state_r == ST_WAIT) |=> SDA_OE_N_OUT) else $error("drive while unaddressed");
	a_en_off_power: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
		!sysreg_r[LSC_W_EN] |=> !POWER_ON_OUT && LEVEL_OUT == LSC_LVL_OFF
		&& !TONE_ACTIVE_OUT) else $error("power with enable low");
	a_aux_top_level: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
		(sysreg_r[LSC_W_EN] && sysreg_r[LSC_W_AUX] && !diag.over_temp_flag)
		|=> LEVEL_OUT == LSC_LVL_22V) else $error("aux did not force top level");
	a_tone_cont: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
		(sysreg_r[7:5] == 3'b011 && sysreg_r[LSC_W_EN] && !diag.over_temp_flag)
		|=> TONE_ACTIVE_OUT) else $error("continuous tone missing");
	a_read_echo: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
		(state_r == ST_RDATA && $past(state_r) != ST_RDATA) |->
		shift_r[4:2] == $past(sysreg_r[4:2])) else $error("readback mismatch");
	a_rd_msb_first: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
		(state_r == ST_ACK && rd_r && sda_low_r && ev.scl_fall && !undervoltage_lockout && !ev.start
		&& !ev.stop) |=> SDA_OE_N_OUT == rd_byte[7] || $changed(rd_byte))
		else $error("read msb not first");
endmodule
`default_nettype wire

/* File: test/lsc_host_model.sv */
/*
 Bus master model standing in for the host controller.
 Assumes a pull-up on both lines; the bench resolves the data wire.
*/
`timescale 1ns/1ns
`default_nettype none
module lsc_host_model (
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_oe_n_out
);
	// Quarter of the 125 ns bus clock period
	localparam int QTR = 31;
	initial begin
		scl_out = 1'b1;
		sda_oe_n_out = 1'b1;
	end
	task automatic start_cond();
		sda_oe_n_out = 1'b1;
		#(QTR);
		sda_oe_n_out = 1'b0;
		#(2 * QTR);
		scl_out = 1'b0;
	endtask
	task automatic stop_cond();
		#(QTR);
		sda_oe_n_out = 1'b0;
		#(QTR);
		scl_out = 1'b1;
		#(QTR);
		sda_oe_n_out = 1'b1;
		#(2 * QTR);
	endtask
	// Byte plus ninth clock; tx 8'hFF leaves the line to the device
	task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
		output logic ack_n);
		logic [8:0] bits;
		bits = {tx, last};
		for (int i = 8; i >= 0; i--) begin
			#(QTR);
			sda_oe_n_out = bits[i];
			#(QTR);
			scl_out = 1'b1;
			#(QTR);
			if (i > 0) begin
				rx[i-1] = sda_in;
			end else begin
				ack_n = sda_in;
			end
			#(QTR + 1);
			scl_out = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
/*
 Self-checking bench for the supply-controller serial slave.
 Assumes the host model in lsc_host_model and the package lsc_pkg.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top import lsc_pkg::*; ;
	logic clk;
	logic rst;
	logic undervoltage_lockout;
	logic gate;
	logic asel;
	logic [4:0] flt;
	integer seed;
	int num_errors;
	int n_tests;
	wire logic scl;
	wire logic host_oe_n;
	wire logic dev_sda;
	wire logic dev_oe_n;
	wire logic sda;
	wire logic [2:0] lvl;
	wire logic [5:0] flags;
	wire logic [8:0] outs;
	// Pull-up wins unless someone pulls low
	assign sda = !host_oe_n ? 1'b0 : (!dev_oe_n ? dev_sda : 1'b1);
	assign outs = {lvl, flags};

	lsc_top uut (
		.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(dev_sda), .SDA_OE_N_OUT(dev_oe_n), .ADDR_SEL_IN(asel),
		.UNDERVOLTAGE_LOCKOUT_IN(undervoltage_lockout), .TONE_GATE_IN(gate),
		.MIN_CURRENT_FAULT_IN(flt[4]), .VOLTAGE_FAULT_IN(flt[3]), .TONE_FAULT_IN(flt[2]),
		.OVER_TEMP_IN(flt[1]), .OVERLOAD_IN(flt[0]), .LEVEL_OUT(lvl),
		.POWER_ON_OUT(flags[5]), .MAIN_OUTPUT_ON_OUT(flags[4]),
		.TONE_OUTPUT_ON_OUT(flags[3]), .TONE_ACTIVE_OUT(flags[2]),
		.STATIC_LIMIT_OUT(flags[1]), .HIGH_MIN_THRESH_OUT(flags[0])
	);
	lsc_host_model host (.sda_in(sda), .scl_out(scl), .sda_oe_n_out(host_oe_n));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	function automatic lsc_ctrl_t exp_ctrl(input logic [7:0] r, input logic g);
		lsc_ctrl_t c;
		c = '0;
		if (r[LSC_W_EN]) begin
			case ({r[LSC_W_AUX], r[LSC_W_LLC], r[LSC_W_VOLTAGE_SELECT]})
				3'b000: c.level = LSC_LVL_13V4;
				3'b001: c.level = LSC_LVL_18V5;
				3'b010: c.level = LSC_LVL_14V4;
				3'b011: c.level = LSC_LVL_19V5;
				default: c.level = LSC_LVL_22V;
			endcase
			c.power_on = 1'b1;
			c.main_output_on = 1'b1;
			c.tone_output_on = r[LSC_W_TONE_PATH];
			c.tone_active = r[LSC_W_TONE_PATH] & (r[LSC_W_TONE_CONT] | g);
			c.static_limit = r[LSC_W_CUR_STYLE];
			c.high_min_thresh = r[LSC_W_ITHR];
		end
		return c;
	endfunction

	// Blind mode sends the data byte without looking at the acknowledge
	task automatic wr(input logic [6:0] adr, input logic [7:0] data, input logic exp_n,
		input logic blind);
		logic [7:0] rx;
		logic ack_n;
		host.start_cond();
		host.xfer({adr, 1'b0}, 1'b1, rx, ack_n);
		chk("addr_ack", {8'h00, ack_n}, {8'h00, exp_n});
		if (ack_n === 1'b0 || blind) begin
			host.xfer(data, 1'b1, rx, ack_n);
			chk("data_ack", {8'h00, ack_n}, {8'h00, exp_n});
		end
		host.stop_cond();
	endtask

	task automatic rd(input logic [6:0] adr, output logic [7:0] b0, output logic [7:0] b1);
		logic ack_n;
		host.start_cond();
		host.xfer({adr, 1'b1}, 1'b1, b0, ack_n);
		chk("rd_ack", {8'h00, ack_n}, 9'h000);
		host.xfer(8'hFF, 1'b0, b0, ack_n);
		host.xfer(8'hFF, 1'b1, b1, ack_n);
		host.stop_cond();
	endtask

	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		test_done();
	end

	initial begin
		logic [6:0] adr;
		logic [7:0] wv;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] er;
		logic [7:0] hv;
		lsc_ctrl_t ec;
		seed = 32'h7682;
		num_errors = 0;
		n_tests = 0;
		rst = 1'b1;
		undervoltage_lockout = 1'b0;
		gate = 1'b0;
		asel = 1'b0;
		flt = 5'h00;
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		repeat (8) @(posedge clk);
		chk("ctrl_after_reset", outs, 9'h000);
		rd({LSC_ADDR_HI, 1'b0}, b0, b1);
		chk("rd_after_reset", {1'b0, b0}, 9'h000);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			#1;
			wv = (k == 0) ? 8'hFF : ((k == 1) ? 8'h04 : 8'($random(seed)));
			asel = 1'($random(seed));
			gate = 1'($random(seed));
			adr = {LSC_ADDR_HI, asel};
			wr({adr[6:1], ~adr[0]}, 8'h5A, 1'b1, 1'b1);
			wr(adr, wv, 1'b0, 1'b0);
			repeat (6) @(posedge clk);
			#1;
			ec = exp_ctrl(wv, gate);
			chk("ctrl", outs, ec);
			chk("ctrl_style_thr", 9'(flags[1:0]), 9'(ec[1:0]));
			flt = (k == 0) ? 5'h1F : 5'($random(seed));
			repeat (6) @(posedge clk);
			#1;
			// Over-temperature takes the power blocks down
			if (flt[1]) begin
				ec.level = LSC_LVL_OFF;
				ec.power_on = 1'b0;
				ec.main_output_on = 1'b0;
				ec.tone_output_on = 1'b0;
				ec.tone_active = 1'b0;
			end
			chk("ctrl_over_temp", outs, ec);
			er = {flt[4:2], wv[4:2], flt[1:0]};
			rd(adr, b0, b1);
			chk("rd_byte0", {1'b0, b0}, {1'b0, er});
			chk("rd_byte1", {1'b0, b1}, {1'b0, er});
			// Host software masks the flags that it must not trust
			hv = {~(wv[LSC_W_EN] & wv[LSC_W_TONE_PATH]), ~wv[LSC_W_LLC], 6'h3F};
			chk("rd_host_view", {1'b0, b0 & hv}, {1'b0, er & hv});
			flt = 5'h00;
		end
		@(posedge clk);
		#1 undervoltage_lockout = 1'b1;
		repeat (8) @(posedge clk);
		chk("ctrl_lockout", outs, 9'h000);
		wr(adr, 8'hFF, 1'b1, 1'b1);
		chk("ctrl_lockout_wr", outs, 9'h000);
		@(posedge clk);
		#1 undervoltage_lockout = 1'b0;
		repeat (8) @(posedge clk);
		rd(adr, b0, b1);
		chk("rd_after_lockout", {1'b0, b0}, 9'h000);
		test_done();
	end
endmodule
`default_nettype wire
